// file: drp_pkg.sv
// drp_pkg: constants, command pin struct and state encoding for the ddr2 command model
// assumes: one clock at 10 MHz, registers reached over apb
package drp_pkg;
   localparam int unsigned CLK_NS        = 100;
   localparam int unsigned TREFI_NS      = 7800;
   localparam int unsigned TREFI_CYC     = TREFI_NS / CLK_NS;
   localparam int unsigned ROW_W         = 13;
   localparam int unsigned NBANK         = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_TIM0      = 8'h04;
   localparam logic [7:0]  OFS_TIM1      = 8'h08;
   localparam logic [7:0]  OFS_STAT      = 8'h0C;
   localparam logic [7:0]  OFS_ROW       = 8'h10;
   // ctrl fields
   localparam int unsigned CTRL_WR_LSB   = 0;
   localparam int unsigned CTRL_BL8_BIT  = 3;
   localparam int unsigned CTRL_SLOW_BIT = 4;
   localparam int unsigned CTRL_WL_LSB   = 5;
   localparam int unsigned CTRL_AL_LSB   = 8;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0043;
   localparam logic [31:0] CTRL_MASK     = 32'h0000_07FF;
   // tim0: tras [7:0], trp [15:8], trfc [23:16]; tim1: txp, txard, txards, txsnr
   localparam logic [31:0] TIM0_RST      = 32'h0002_0304;
   localparam logic [31:0] TIM1_RST      = 32'h0402_0202;
   localparam logic [7:0]  BL4_HALF      = 8'h02;
   localparam logic [7:0]  BL8_HALF      = 8'h04;

   typedef struct packed {
      logic       cke;
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic       odt;
      logic       a10;
      logic [2:0] ba;
   } drp_pins_s;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_PDN  = 2'b01,
      ST_SREF = 2'b11,
      ST_SRX  = 2'b10
   } drp_state_e;
endpackage

// file: drp_bank.sv
// drp_bank: one bank's open row, tras lockout, auto-precharge and trp timing
// assumes: command strobes are single-cycle and already decoded for this bank
`timescale 1ns/1ps
module drp_bank
   import drp_pkg::*;
(
   input  wire logic       pclk,     // clock
   input  wire logic       presetn,  // async reset, low
   input  wire logic       act,      // activate
   input  wire logic       wr_ap,    // write with auto-precharge
   input  wire logic       rd_ap,    // read with auto-precharge
   input  wire logic       pre,      // explicit precharge
   input  wire logic [7:0] wap_dly,  // wl + bl/2 + wr
   input  wire logic [7:0] rap_dly,  // al + bl/2
   input  wire logic [7:0] tras,     // tras in cycles
   input  wire logic [7:0] trp,      // trp in cycles
   output logic            open,     // row open
   output logic            busy,     // precharge pending or running
   output logic            ap_start  // internal precharge began
);
   logic       open_q, open_d, pend_q, pend_d, ap_q, ap_d;
   logic [7:0] ras_q, ras_d, pcnt_q, pcnt_d, rp_q, rp_d;

   always_comb
   begin
      open_d = open_q;
      pend_d = pend_q;
      ap_d   = 1'b0;
      ras_d  = (ras_q != 8'h00) ? ras_q - 8'h01 : ras_q;
      pcnt_d = (pcnt_q != 8'h00) ? pcnt_q - 8'h01 : pcnt_q;
      rp_d   = (rp_q != 8'h00) ? rp_q - 8'h01 : rp_q;
      if (act)
      begin
         open_d = 1'b1;
         ras_d  = tras;
      end
      if (wr_ap || rd_ap)
      begin
         pend_d = 1'b1;
         pcnt_d = wr_ap ? wap_dly : rap_dly;
      end
      else if (pend_q && pcnt_q == 8'h00 && ras_q == 8'h00)
      begin
         pend_d = 1'b0;
         open_d = 1'b0;
         rp_d   = trp;
         ap_d   = 1'b1;
      end
      if (pre)
      begin
         open_d = 1'b0;
         rp_d   = trp;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         open_q <= 1'b0;
         pend_q <= 1'b0;
         ap_q   <= 1'b0;
         ras_q  <= 8'h00;
         pcnt_q <= 8'h00;
         rp_q   <= 8'h00;
      end
      else
      begin
         open_q <= open_d;
         pend_q <= pend_d;
         ap_q   <= ap_d;
         ras_q  <= ras_d;
         pcnt_q <= pcnt_d;
         rp_q   <= rp_d;
      end
   end

   assign open     = open_q;
   assign busy     = pend_q || (rp_q != 8'h00);
   assign ap_start = ap_q;
endmodule // drp_bank

// file: drp_refresh.sv
// drp_refresh: internal refresh row counter, trfc busy time, self-refresh timer
// assumes: ref_cmd is one cycle per auto-refresh; self_en high during self-refresh
`timescale 1ns/1ps
module drp_refresh
   import drp_pkg::*;
(
   input  wire logic             pclk,    // clock
   input  wire logic             presetn, // async reset, low
   input  wire logic             ref_cmd, // auto-refresh registered
   input  wire logic             self_en, // self-refresh active
   input  wire logic [7:0]       trfc,    // trfc in cycles
   output logic      [ROW_W-1:0] row,     // next row to refresh
   output logic                  busy,    // refresh cycle running
   output logic                  strobe   // a row was refreshed
);
   localparam logic [7:0] TREFI_C = 8'(TREFI_CYC);
   logic [ROW_W-1:0] row_q, row_d;
   logic [7:0]       rfc_q, rfc_d, tmr_q, tmr_d;
   logic             stb_q, stb_d, tick;

   always_comb
   begin
      tick  = self_en && (tmr_q == 8'h00);
      tmr_d = !self_en ? TREFI_C : (tick ? TREFI_C : tmr_q - 8'h01);
      stb_d = ref_cmd || tick;
      row_d = stb_d ? row_q + 1'b1 : row_q;
      rfc_d = stb_d ? trfc : ((rfc_q != 8'h00) ? rfc_q - 8'h01 : rfc_q);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         row_q <= '0;
         rfc_q <= 8'h00;
         tmr_q <= TREFI_C;
         stb_q <= 1'b0;
      end
      else
      begin
         row_q <= row_d;
         rfc_q <= rfc_d;
         tmr_q <= tmr_d;
         stb_q <= stb_d;
      end
   end

   assign row    = row_q;
   assign busy   = rfc_q != 8'h00;
   assign strobe = stb_q;
endmodule // drp_refresh

// file: drp_top.sv
// drp_top: ddr2 command-level model: auto-precharge, refresh, self-refresh, power-down
// assumes: command pins synchronous to pclk; registers over apb, zero wait states
`timescale 1ns/1ps
module drp_top
   import drp_pkg::*;
(
   input  wire logic             pclk,       // 10 MHz clock
   input  wire logic             presetn,    // async reset, low
   input  wire logic             psel,       // apb select
   input  wire logic             penable,    // apb enable
   input  wire logic             pwrite,     // apb direction
   input  wire logic [7:0]       paddr,      // apb byte address
   input  wire logic [31:0]      pwdata,     // apb write data
   output logic      [31:0]      prdata,     // apb read data
   output logic                  pready,     // apb ready
   output logic                  pslverr,    // apb error
   input  wire drp_pins_s        pins,       // command pins
   output logic      [NBANK-1:0] bank_open,  // rows open per bank
   output logic      [NBANK-1:0] ap_strobe,  // internal precharge began
   output logic      [ROW_W-1:0] ref_row,    // refresh row counter
   output logic                  ref_strobe, // refresh of one row
   output logic                  in_buf_en,  // input/output buffers on
   output logic                  clk_gated,  // internal clock stopped
   output logic                  dll_on,     // dll running
   output logic                  odt_en,     // termination active
   output logic                  exit_busy   // exit latency running
);
   drp_state_e st_q, st_d;
   logic [31:0] ctrl_q, ctrl_d, tim0_q, tim0_d, tim1_q, tim1_d;
   logic [31:0] rd_q, rd_d;
   logic        err_q, err_d, cke_q, cke_d, dll_q, dll_d;
   logic [7:0]  xc_q, xc_d;
   logic [7:0]  bl_half, wap_dly, rap_dly;
   logic        cmd_ok, nop, c_act, c_ref, c_pre, c_wr, c_rd;
   logic        ref_busy, any_open, setup, wr_en;
   logic [NBANK-1:0] b_act, b_wap, b_rap, b_pre, b_busy;

   function automatic logic is_nop(input drp_pins_s p);
      is_nop = p.cs_n || (p.ras_n && p.cas_n && p.we_n);
   endfunction

   function automatic logic is_cmd(input drp_pins_s p, input logic r, input logic c, input logic w);
      is_cmd = !p.cs_n && p.ras_n == r && p.cas_n == c && p.we_n == w;
   endfunction

   function automatic logic [7:0] field(input logic [31:0] r, input int unsigned lsb);
      field = r[lsb +: 8];
   endfunction

   // command decode, only while running and not in an exit interval
   always_comb
   begin
      cmd_ok = (st_q == ST_RUN) && cke_q && pins.cke && !exit_busy;
      nop    = is_nop(pins);
      c_act  = cmd_ok && is_cmd(pins, 1'b0, 1'b1, 1'b1);
      c_ref  = cmd_ok && is_cmd(pins, 1'b0, 1'b0, 1'b1);
      c_pre  = cmd_ok && is_cmd(pins, 1'b0, 1'b1, 1'b0);
      c_wr   = cmd_ok && is_cmd(pins, 1'b1, 1'b0, 1'b0);
      c_rd   = cmd_ok && is_cmd(pins, 1'b1, 1'b0, 1'b1);
   end

   assign bl_half = ctrl_q[CTRL_BL8_BIT] ? BL8_HALF : BL4_HALF;
   // write ap: burst end (wl + bl/2) then programmed write recovery
   assign wap_dly = 8'(ctrl_q[CTRL_WL_LSB +: 3]) + bl_half + 8'(ctrl_q[CTRL_WR_LSB +: 3]);
   assign rap_dly = 8'(ctrl_q[CTRL_AL_LSB +: 3]) + bl_half;

   // per-bank strobes; other banks stay free during auto-precharge
   genvar gi;
   generate
      for (gi = 0; gi < NBANK; gi++)
      begin : g_bank
         logic hit;
         assign hit       = pins.ba == 3'(gi);
         assign b_act[gi] = c_act && hit;
         assign b_wap[gi] = c_wr && pins.a10 && hit;
         assign b_rap[gi] = c_rd && pins.a10 && hit;
         assign b_pre[gi] = c_pre && (pins.a10 || hit);
         drp_bank u_bank (
            .pclk     (pclk),
            .presetn  (presetn),
            .act      (b_act[gi]),
            .wr_ap    (b_wap[gi]),
            .rd_ap    (b_rap[gi]),
            .pre      (b_pre[gi]),
            .wap_dly  (wap_dly),
            .rap_dly  (rap_dly),
            .tras     (field(tim0_q, 0)),
            .trp      (field(tim0_q, 8)),
            .open     (bank_open[gi]),
            .busy     (b_busy[gi]),
            .ap_start (ap_strobe[gi])
         );
      end
   endgenerate

   assign any_open = |bank_open;

   drp_refresh u_ref (
      .pclk    (pclk),
      .presetn (presetn),
      .ref_cmd (c_ref),
      .self_en (st_q == ST_SREF),
      .trfc    (field(tim0_q, 16)),
      .row     (ref_row),
      .busy    (ref_busy),
      .strobe  (ref_strobe)
   );

   // power state machine
   always_comb
   begin
      st_d  = st_q;
      cke_d = pins.cke;
      dll_d = dll_q;
      xc_d  = (xc_q != 8'h00) ? xc_q - 8'h01 : xc_q;
      case (st_q)
         ST_RUN:
         begin
            if (cke_q && !pins.cke && !exit_busy)
            begin
               if (is_cmd(pins, 1'b0, 1'b0, 1'b1))
               begin
                  st_d  = ST_SREF;
                  dll_d = 1'b0;
               end
               else if (nop)
               begin
                  st_d  = ST_PDN;
                  dll_d = any_open && !ctrl_q[CTRL_SLOW_BIT];
               end
            end
         end
         ST_PDN:
         begin
            if (pins.cke && nop)
            begin
               st_d  = ST_RUN;
               dll_d = 1'b1;
               if (!any_open)
                  xc_d = field(tim1_q, 0);
               else if (ctrl_q[CTRL_SLOW_BIT])
                  xc_d = field(tim1_q, 16);
               else
                  xc_d = field(tim1_q, 8);
            end
         end
         ST_SREF:
         begin
            // exit is taken at the next pclk edge: cke high alone ends it
            if (pins.cke)
            begin
               st_d  = ST_SRX;
               dll_d = 1'b1;
               xc_d  = field(tim1_q, 24);
            end
         end
         ST_SRX:
         begin
            if (xc_q == 8'h00)
               st_d = ST_RUN;
         end
         default:
         begin
            st_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q  <= ST_RUN;
         cke_q <= 1'b0;
         dll_q <= 1'b1;
         xc_q  <= 8'h00;
      end
      else
      begin
         st_q  <= st_d;
         cke_q <= cke_d;
         dll_q <= dll_d;
         xc_q  <= xc_d;
      end
   end

   assign exit_busy = xc_q != 8'h00;
   assign in_buf_en = st_q == ST_RUN || st_q == ST_SRX;
   assign clk_gated = st_q == ST_SREF;
   assign dll_on    = dll_q;
   assign odt_en    = pins.odt && st_q != ST_SREF && st_q != ST_SRX;

   // apb slave: read data latched in setup, answer in the access cycle
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite;

   always_comb
   begin
      ctrl_d = ctrl_q;
      tim0_d = tim0_q;
      tim1_d = tim1_q;
      rd_d   = rd_q;
      err_d  = err_q;
      if (setup)
      begin
         err_d = 1'b0;
         rd_d  = 32'h0000_0000;
         case (paddr)
            OFS_CTRL: rd_d = ctrl_q;
            OFS_TIM0: rd_d = tim0_q;
            OFS_TIM1: rd_d = tim1_q;
            OFS_STAT: rd_d = {11'h000, exit_busy, ref_busy, dll_q, st_q, b_busy, bank_open};
            OFS_ROW:  rd_d = 32'(ref_row);
            default:  err_d = 1'b1;
         endcase
      end
      if (wr_en)
      begin
         case (paddr)
            OFS_CTRL: ctrl_d = pwdata & CTRL_MASK;
            OFS_TIM0: tim0_d = {8'h00, pwdata[23:0]};
            OFS_TIM1: tim1_d = pwdata;
            default:  ctrl_d = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= CTRL_RST;
         tim0_q <= TIM0_RST;
         tim1_q <= TIM1_RST;
         rd_q   <= 32'h0000_0000;
         err_q  <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         tim0_q <= tim0_d;
         tim1_q <= tim1_d;
         rd_q   <= rd_d;
         err_q  <= err_d;
      end
   end

   assign prdata  = rd_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && err_q;
endmodule // drp_top

// file: drp_chk.sv
// drp_chk: port-level assertions for drp_top
// assumes: one clock, presetn asynchronous active low
`timescale 1ns/1ps
module drp_chk
   import drp_pkg::*;
(
   input  wire logic             pclk,       // clock
   input  wire logic             presetn,    // async reset, low
   input  wire drp_pins_s        pins,       // command pins
   input  wire logic [NBANK-1:0] bank_open,  // rows open
   input  wire logic [NBANK-1:0] ap_strobe,  // internal precharge
   input  wire logic [ROW_W-1:0] ref_row,    // refresh row
   input  wire logic             ref_strobe, // row refreshed
   input  wire logic             in_buf_en,  // buffers on
   input  wire logic             clk_gated,  // clock stopped
   input  wire logic             dll_on,     // dll running
   input  wire logic             odt_en,     // termination
   input  wire logic             exit_busy   // exit latency
);
   logic       cke_q;
   logic [2:0] ba_q;
   logic       run, cmd, nop, pdn, ref_c, act_c, sref_c, pd_c;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cke_q <= 1'h0;
         ba_q  <= 3'h0;
      end
      else
      begin
         cke_q <= pins.cke;
         ba_q  <= pins.ba;
      end
   end
   assign run    = in_buf_en & ~exit_busy & ~clk_gated & cke_q;
   assign pdn    = ~in_buf_en & ~clk_gated;
   assign nop    = pins.cs_n | (pins.ras_n & pins.cas_n & pins.we_n);
   assign cmd    = run & pins.cke & ~pins.cs_n;
   assign ref_c  = cmd & ~pins.ras_n & ~pins.cas_n & pins.we_n;
   assign act_c  = cmd & ~pins.ras_n & pins.cas_n & pins.we_n;
   assign sref_c = run & ~pins.cke & ~pins.cs_n & ~pins.ras_n & ~pins.cas_n & pins.we_n;
   assign pd_c   = run & ~pins.cke & nop;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ref_strobe_due: assert property (ref_c |-> ##[1:2] ref_strobe)
      else $error("refresh gave no row strobe");
   a_row_step_one: assert property (ref_row != $past(ref_row) |-> ref_row == ROW_W'($past(ref_row) + 1))
      else $error("refresh row did not step by one");
   a_ref_banks_idle: assert property (ref_strobe |-> bank_open == '0)
      else $error("bank open during refresh");
   a_sref_entry: assert property (sref_c |=> clk_gated && !in_buf_en && !dll_on)
      else $error("self-refresh not entered");
   a_sref_stay_odt: assert property (clk_gated && !pins.cke |=> clk_gated && !odt_en)
      else $error("self-refresh left or odt on");
   a_pd_entry: assert property (pd_c |=> pdn)
      else $error("power-down not entered");
   a_pd_hold: assert property (pdn && !pins.cke |=> pdn && ($stable(bank_open) || |ap_strobe))
      else $error("power-down state disturbed");
   a_pd_odt_live: assert property (pdn |-> odt_en == pins.odt)
      else $error("odt not live in power-down");
   a_pd_idle_dll: assert property (pd_c && bank_open == '0 |=> !dll_on)
      else $error("dll on in precharge power-down");
   a_pd_exit: assert property (pdn && pins.cke && nop |=> in_buf_en)
      else $error("power-down not left");
   a_act_opens: assert property (act_c |=> bank_open[ba_q])
      else $error("activate did not open bank");
   a_ap_closes: assert property (|ap_strobe |-> (bank_open & ap_strobe) == '0)
      else $error("bank open at auto-precharge");
endmodule // drp_chk

bind drp_top drp_chk i_chk
(
   .pclk       (pclk),
   .presetn    (presetn),
   .pins       (pins),
   .bank_open  (bank_open),
   .ap_strobe  (ap_strobe),
   .ref_row    (ref_row),
   .ref_strobe (ref_strobe),
   .in_buf_en  (in_buf_en),
   .clk_gated  (clk_gated),
   .dll_on     (dll_on),
   .odt_en     (odt_en),
   .exit_busy  (exit_busy)
);

// file: drp_ctl.sv
// drp_ctl: behavioural ddr2 controller on command, cke and odt pins
// assumes: bench calls its tasks; pins change just after rising edges
`timescale 1ns/1ps
module drp_ctl
   import drp_pkg::*;
(
   input  wire logic pclk, // clock
   output drp_pins_s pins  // command pins
);
   localparam drp_pins_s NOP = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 3'h0};

   initial pins = NOP;

   // one command edge, then nop with cke high
   task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic a10, input logic odt);
      @(posedge pclk);
      pins <= '{1'h1, 1'h0, rcw[2], rcw[1], rcw[0], odt, a10, ba};
      @(posedge pclk);
      pins <= NOP;
   endtask

   // cke low for n+1 edges; other pins wander, device must ignore all but odt in power-down
   task automatic low(input logic sref, input int n);
      @(posedge pclk);
      pins <= '{1'h0, 1'h0, ~sref, ~sref, 1'h1, 1'h0, 1'h0, 3'h0};
      for (int i = 0; i < n; i++)
      begin
         @(posedge pclk);
         pins <= '{1'h0, i[0], i[1], i[2], i[3], ~sref & i[1], i[4], i[2:0]};
      end
      @(posedge pclk);
      pins <= NOP;
      @(posedge pclk);
   endtask
endmodule // drp_ctl

// file: drp_top_tb_top.sv
// drp_top_tb_top: self-checking bench for drp_top
// assumes: drp_ctl drives the command pins, the bench drives apb
`timescale 1ns/1ps
module drp_top_tb_top
   import drp_pkg::*;
;
   localparam logic [2:0]  C_ACT = 3'h3;
   localparam logic [2:0]  C_WR  = 3'h4;
   localparam logic [2:0]  C_PRE = 3'h2;
   localparam logic [2:0]  C_REF = 3'h1;
   localparam logic [2:0]  C_RD  = 3'h5;
   localparam logic [31:0] TIM1V = 32'h0605_0302;
   logic                   pclk = 1'h0;
   logic                   presetn, psel, penable, pwrite, pready, pslverr;
   logic       [7:0]       paddr;
   logic       [31:0]      pwdata, prdata;
   drp_pins_s              pins;
   logic       [NBANK-1:0] bank_open, ap_strobe;
   logic                   in_buf_en, clk_gated, dll_on, exit_busy;
   int                     error_cnt = 0;
   int                     cmp_count = 0;

   always #50 pclk = ~pclk;

   drp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .bank_open(bank_open), .ap_strobe(ap_strobe),
      .ref_row(), .ref_strobe(), .in_buf_en(in_buf_en), .clk_gated(clk_gated),
      .dll_on(dll_on), .odt_en(), .exit_busy(exit_busy));
   drp_ctl i_ctl (.pclk(pclk), .pins(pins));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic exit_chk(input int exp);
      int n;
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (exit_busy === 1'h1 && n < 40);
      chk(32'(n - 1), 32'(exp));
   endtask

   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      apb(1'h0, OFS_CTRL, 32'h0, r, e);
      chk(r, CTRL_RST);
      apb(1'h0, OFS_TIM0, 32'h0, r, e);
      chk(r, TIM0_RST);
      apb(1'h1, 8'h14, 32'hFFFF_FFFF, r, e);
      chk(32'(e), 32'h1);
      apb(1'h1, OFS_TIM1, TIM1V, r, e);
      apb(1'h0, OFS_TIM1, 32'h0, r, e);
      chk(r, TIM1V);
   endtask

   // read-ap with bl8 and al 1, other bank opened meanwhile
   task automatic t_rap;
      logic [31:0] r;
      logic        e;
      int          n;
      apb(1'h1, OFS_CTRL, 32'h0000_014B, r, e);
      i_ctl.issue(C_ACT, 3'h6, 1'h0, 1'h0);
      repeat (4) @(posedge pclk);
      i_ctl.issue(C_RD, 3'h6, 1'h1, 1'h0);
      i_ctl.issue(C_ACT, 3'h7, 1'h0, 1'h0);
      n = 2;
      while (ap_strobe[6] !== 1'h1 && n < 40)
      begin
         @(negedge pclk);
         n++;
      end
      chk(32'(n), 32'h3 + 32'(BL8_HALF));
      chk(32'(bank_open), 32'h80);
      i_ctl.issue(C_PRE, 3'h7, 1'h0, 1'h0);
   endtask

   // write-ap delay for wr at both ends, other bank opened meanwhile
   task automatic t_wap;
      logic [31:0] r;
      logic        e;
      int          n;
      for (int wr = 2; wr <= 6; wr += 4)
      begin
         apb(1'h1, OFS_CTRL, 32'h40 | 32'(wr), r, e);
         apb(1'h0, OFS_CTRL, 32'h0, r, e);
         chk(r, 32'h40 | 32'(wr));
         i_ctl.issue(C_ACT, 3'h1, 1'h0, 1'h0);
         repeat (5) @(posedge pclk);
         i_ctl.issue(C_WR, 3'h1, 1'h1, 1'h0);
         i_ctl.issue(C_ACT, 3'h2, 1'h0, 1'h0);
         n = 2;
         while (ap_strobe[1] !== 1'h1 && n < 40)
         begin
            @(negedge pclk);
            n++;
         end
         chk(32'(n >= wr + 5 && n <= wr + 6), 32'h1);
         chk(32'(bank_open), 32'h4);
         i_ctl.issue(C_PRE, 3'h2, 1'h0, 1'h0);
         repeat (8) @(posedge pclk);
      end
   endtask

   task automatic t_ref;
      logic [31:0] r0, r;
      logic        e;
      i_ctl.issue(C_PRE, 3'h0, 1'h1, 1'h0);
      repeat (3) @(posedge pclk);
      apb(1'h0, OFS_ROW, 32'h0, r0, e);
      for (int i = 0; i < 2; i++)
      begin
         i_ctl.issue(C_REF, 3'(5 + i), 1'h1, 1'h0);
         repeat (3) @(posedge pclk);
      end
      apb(1'h0, OFS_ROW, 32'h0, r, e);
      chk(r, r0 + 32'h2);
      chk(32'(bank_open), 32'h0);
   endtask

   task automatic t_pdn;
      logic [31:0] r;
      logic        e;
      logic [7:0]  held;
      int          xs[3] = '{3, 5, 2};
      i_ctl.issue(C_ACT, 3'h3, 1'h0, 1'h0);
      for (int c = 0; c < 3; c++)
      begin
         apb(1'h1, OFS_CTRL, (c == 1) ? 32'h53 : 32'h43, r, e);
         if (c == 2)
         begin
            i_ctl.issue(C_PRE, 3'h0, 1'h1, 1'h0);
            repeat (3) @(posedge pclk);
         end
         held = bank_open;
         fork
            i_ctl.low(1'h0, 8);
            begin
               repeat (4) @(negedge pclk);
               chk(32'(in_buf_en), 32'h0);
               chk(32'(dll_on), 32'(c == 0));
               chk(32'(bank_open), 32'(held));
            end
         join
         exit_chk(xs[c]);
      end
   endtask

   task automatic t_sref;
      logic [31:0] r0, r;
      logic        e;
      repeat (3) @(posedge pclk);
      apb(1'h0, OFS_ROW, 32'h0, r0, e);
      fork
         i_ctl.low(1'h1, 200);
         begin
            repeat (4) @(negedge pclk);
            chk(32'(clk_gated), 32'h1);
            chk(32'(dll_on), 32'h0);
         end
      join
      exit_chk(6);
      apb(1'h0, OFS_ROW, 32'h0, r, e);
      chk(32'(r - r0 >= 2 && r - r0 <= 3), 32'h1);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // about six times the expected run
   initial
   begin
      #250000;
      error_cnt++;
      report_and_stop;
   end

   initial
   begin
      presetn = 1'h0;
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
      t_regs;
      t_wap;
      t_rap;
      t_ref;
      t_pdn;
      t_sref;
      report_and_stop;
   end
endmodule // drp_top_tb_top
